// File: logic/fip_pkg.sv
// Shared constants for the flag, interrupt request and timer pin block
package fip_pkg;

   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register offsets (word index on the plain register port)
   localparam logic [3:0] ADDR_FLAG_DIR = 4'h0;
   localparam logic [3:0] ADDR_FLAG_OUT = 4'h1;
   localparam logic [3:0] ADDR_FLAG_IN = 4'h2;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
   localparam logic [3:0] ADDR_IRQ_MODE = 4'h4;
   localparam logic [3:0] ADDR_EVT_STAT = 4'h5;
   localparam logic [3:0] ADDR_EVT_MASK = 4'h6;
   localparam logic [3:0] ADDR_STRAP = 4'h7;
   localparam logic [3:0] ADDR_IRQ_REQ = 4'h8;

   // Event status and mask layout
   localparam int EVT_W = 9;
   localparam int EVT_IRQ_LSB = 0;
   localparam int EVT_TMR_BIT = 4;
   localparam int EVT_COND_LSB = 5;

   // Strap register layout
   localparam int STRAP_TMR_BIT = 0;
   localparam int STRAP_BOOT_BIT = 1;
   localparam int STRAP_PEND_BIT = 2;

   // Reset values and the interrupt boot enable value
   localparam logic [3:0] RST_FLAG_DIR = 4'h0;
   localparam logic [3:0] RST_FLAG_OUT = 4'h0;
   localparam logic [3:0] RST_IRQ_EN = 4'h0;
   localparam logic [3:0] RST_IRQ_MODE = 4'h0;
   localparam logic [8:0] RST_EVT_MASK = 9'h000;
   localparam logic [3:0] BOOT_IRQ_EN = 4'hf;

endpackage : fip_pkg

// File: logic/fip_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fip_sync #(
   parameter int W = 4
) (
   // Clock
   input wire logic CLK_I,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } fip_sync_st_t;

   fip_sync_st_t st;
   fip_sync_st_t next_st;

   initial begin
      if (W < 1) begin
         $error("fip_sync: W must be at least 1");
      end
   end

   // No reset: straps must pass while reset is held
   always_comb begin
      next_st = st;
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Stage one feeds only stage two; accept a bit once stages two and three agree
      next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
   end

   always_ff @(posedge CLK_I) begin
      st <= next_st;
   end

   assign q_o = st.q;

endmodule : fip_sync

// File: logic/fip_irq_in.sv
// One external interrupt request channel: edge latch or level follow
`timescale 1ns/1ps
module fip_irq_in (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Synchronised request, active high
   input wire logic asserted_i,
   // Control
   input wire logic en_i,
   input wire logic edge_i,
   input wire logic ack_i,
   // Results
   output logic req_o,
   output logic evt_o
);
   typedef struct packed {
      logic prev;
      logic pend;
      logic req;
      logic evt;
   } fip_irq_st_t;

   fip_irq_st_t st;
   fip_irq_st_t next_st;
   logic rise;

   always_comb begin
      next_st = st;
      rise = asserted_i & ~st.prev;
      next_st.prev = asserted_i;
      // New edge wins over an acknowledge in the same cycle
      next_st.pend = en_i & edge_i & (rise | (st.pend & ~ack_i)); // see RL5
      next_st.req = edge_i ? next_st.pend : (en_i & asserted_i); // see RL4 see RL5
      next_st.evt = en_i & rise;
      if (RST_I) begin
         next_st = '0;
      end
   end

   always_ff @(posedge CLK_I) begin
      st <= next_st;
   end

   assign req_o = st.req;
   assign evt_o = st.evt;

endmodule : fip_irq_in

// File: logic/fip_top.sv
// Condition pins, external interrupt requests and timer 0 expiry pin
//
// Function
// RL1 - Four condition pins each have their own direction bit, input or output.
// RL2 - After reset every condition pin is an input with its driver off.
// RL3 - The synchronised level of each condition pin goes to the program sequencer.
// RL4 - An asserted and enabled interrupt request input raises its request to the interrupt controller.
// RL5 - Each request input is set independently to latch an edge or to follow the level.
// RL6 - Requests stay disabled after reset unless the boot strap selects interrupt boot and vectors are ready.
// RL7 - Each timer 0 expiry produces exactly one pulse on the timer expired pin.
// RL8 - During reset the timer pin is an input strap sampled by the device, and is driven only after reset.
// RL9 - Every asynchronous pin input passes a synchroniser before any use.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module fip_top
   import fip_pkg::*;
#(
   parameter int N_COND = 4,
   parameter int N_IRQ = 4
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WE_I,
   input wire logic RE_I,
   output logic [DATA_W-1:0] RDATA_O,
   // Condition pins
   input wire logic [N_COND-1:0] COND_PINS_I,
   output logic [N_COND-1:0] COND_PINS_O,
   output logic [N_COND-1:0] COND_PINS_OE_O,
   // Condition levels to the program sequencer
   output logic [N_COND-1:0] COND_LEVEL_O,
   // External interrupt request pins, active low
   input wire logic [N_IRQ-1:0] EXT_IRQ_N_I,
   // Interrupt controller side
   output logic [N_IRQ-1:0] IRQ_REQ_O,
   input wire logic [N_IRQ-1:0] IRQ_ACK_I,
   input wire logic VEC_INIT_I,
   // Interrupt boot strap pin
   input wire logic IRQ_BOOT_STRAP_I,
   // Timer 0
   input wire logic TIMER0_EXPIRE_I,
   input wire logic TIMER0_EXPIRED_OUT_I,
   output logic TIMER0_EXPIRED_OUT_O,
   output logic TIMER0_EXPIRED_OUT_OE_O,
   output logic TIMER0_STRAP_O,
   // Block interrupt
   output logic INT_O
);

   initial begin
      if (N_COND != 4) begin
         $error("fip_top: N_COND must be 4 to match the register layout");
      end
      if (N_IRQ != 4) begin
         $error("fip_top: N_IRQ must be 4 to match the register layout");
      end
   end

   typedef struct packed {
      logic [3:0] dir;
      logic [3:0] dout;
      logic [3:0] oe;
      logic [3:0] en;
      logic [3:0] mode;
      logic [8:0] stat;
      logic [8:0] mask;
      logic [3:0] cond_prev;
      logic cond_valid;
      logic tmr_strap;
      logic boot_strap;
      logic boot_pend;
      logic exp_prev;
      logic tmr_o;
      logic tmr_oe;
      logic int_o;
      logic [DATA_W-1:0] rdata;
   } fip_top_st_t;

   fip_top_st_t st;
   fip_top_st_t next_st;

   // Synchronised pin levels and per-channel request outputs
   logic [3:0] cond_sync;
   logic [3:0] irq_n_sync;
   logic [1:0] strap_sync;
   logic [3:0] irq_req;
   logic [3:0] irq_evt;

   // Write decode, timer edge and event detection helpers
   logic wr_hit;
   logic [3:0] wr_addr;
   logic exp_rise;
   logic [8:0] evt_set;
   logic [3:0] cond_chg;

   function automatic logic [DATA_W-1:0] fip_zext4(input logic [3:0] v);
      fip_zext4 = {{(DATA_W-4){1'b0}}, v};
   endfunction : fip_zext4

   function automatic logic [DATA_W-1:0] fip_zext9(input logic [8:0] v);
      fip_zext9 = {{(DATA_W-9){1'b0}}, v};
   endfunction : fip_zext9

   // Every asynchronous pin goes through the three-stage synchroniser and its filter flop first
   fip_sync #(
      .W(4)
   ) u_cond_sync (
      .CLK_I(CLK_I),
      .d_i(COND_PINS_I),
      .q_o(cond_sync)
   ); // see RL9

   fip_sync #(
      .W(4)
   ) u_irq_sync (
      .CLK_I(CLK_I),
      .d_i(EXT_IRQ_N_I),
      .q_o(irq_n_sync)
   ); // see RL9

   fip_sync #(
      .W(2)
   ) u_strap_sync (
      .CLK_I(CLK_I),
      .d_i({IRQ_BOOT_STRAP_I, TIMER0_EXPIRED_OUT_I}),
      .q_o(strap_sync)
   ); // see RL9

   // Per-channel request logic
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_irq
         fip_irq_in u_irq (
            .CLK_I(CLK_I),
            .RST_I(RST_I),
            .asserted_i(~irq_n_sync[gi]),
            .en_i(st.en[gi]),
            .edge_i(st.mode[gi]),
            .ack_i(IRQ_ACK_I[gi]),
            .req_o(irq_req[gi]),
            .evt_o(irq_evt[gi])
         ); // see RL4 see RL5
      end
   endgenerate

   always_comb begin
      next_st = st;
      wr_hit = WE_I;
      wr_addr = ADDR_I;

      // Timer expiry is a level from the timer; one pulse per rising edge
      exp_rise = TIMER0_EXPIRE_I & ~st.exp_prev; // see RL7
      next_st.exp_prev = TIMER0_EXPIRE_I;

      // Input change detection on pins set as inputs
      cond_chg = (cond_sync ^ st.cond_prev) & ~st.dir & {4{st.cond_valid}};
      next_st.cond_prev = cond_sync;
      next_st.cond_valid = 1'b1;

      evt_set = '0;
      evt_set[EVT_IRQ_LSB +: 4] = irq_evt;
      evt_set[EVT_TMR_BIT] = exp_rise & st.tmr_oe;
      evt_set[EVT_COND_LSB +: 4] = cond_chg;

      // Register writes
      if (wr_hit) begin
         case (wr_addr)
            ADDR_FLAG_DIR: begin
               next_st.dir = WDATA_I[3:0]; // see RL1
            end
            ADDR_FLAG_OUT: begin
               next_st.dout = WDATA_I[3:0];
            end
            ADDR_IRQ_EN: begin
               // Software takes over; a pending boot enable is dropped
               next_st.en = WDATA_I[3:0];
               next_st.boot_pend = 1'b0;
            end
            ADDR_IRQ_MODE: begin
               next_st.mode = WDATA_I[3:0]; // see RL5
            end
            ADDR_EVT_STAT: begin
               next_st.stat = st.stat & ~WDATA_I[8:0];
            end
            ADDR_EVT_MASK: begin
               next_st.mask = WDATA_I[8:0];
            end
            default: begin
               next_st.dir = st.dir;
            end
         endcase
      end

      // Hardware set wins over a write-one-to-clear in the same cycle
      next_st.stat = next_st.stat | evt_set;

      // Boot by interrupt: enable all requests once vectors are initialised
      if (st.boot_pend && VEC_INIT_I && !wr_hit) begin
         next_st.en = BOOT_IRQ_EN; // see RL6
         next_st.boot_pend = 1'b0;
      end

      // Output drivers follow direction
      next_st.oe = next_st.dir; // see RL1

      // Timer pin driven only once out of reset
      next_st.tmr_oe = 1'b1; // see RL8
      next_st.tmr_o = exp_rise; // see RL7

      next_st.int_o = |(next_st.stat & next_st.mask);

      // Registered read data, valid the cycle after the strobe
      next_st.rdata = '0;
      if (RE_I) begin
         case (ADDR_I)
            ADDR_FLAG_DIR: begin
               next_st.rdata = fip_zext4(st.dir);
            end
            ADDR_FLAG_OUT: begin
               next_st.rdata = fip_zext4(st.dout);
            end
            ADDR_FLAG_IN: begin
               next_st.rdata = fip_zext4(cond_sync);
            end
            ADDR_IRQ_EN: begin
               next_st.rdata = fip_zext4(st.en);
            end
            ADDR_IRQ_MODE: begin
               next_st.rdata = fip_zext4(st.mode);
            end
            ADDR_EVT_STAT: begin
               next_st.rdata = fip_zext9(st.stat);
            end
            ADDR_EVT_MASK: begin
               next_st.rdata = fip_zext9(st.mask);
            end
            ADDR_STRAP: begin
               next_st.rdata[STRAP_TMR_BIT] = st.tmr_strap;
               next_st.rdata[STRAP_BOOT_BIT] = st.boot_strap;
               next_st.rdata[STRAP_PEND_BIT] = st.boot_pend;
            end
            ADDR_IRQ_REQ: begin
               next_st.rdata = fip_zext4(irq_req);
            end
            default: begin
               next_st.rdata = '0;
            end
         endcase
      end

      // Synchronous reset; straps are sampled for as long as reset is held
      if (RST_I) begin
         next_st = '0;
         next_st.dir = RST_FLAG_DIR; // see RL2
         next_st.oe = '0; // see RL2
         next_st.dout = RST_FLAG_OUT;
         next_st.en = RST_IRQ_EN; // see RL6
         next_st.mode = RST_IRQ_MODE;
         next_st.mask = RST_EVT_MASK;
         next_st.tmr_oe = 1'b0; // see RL8
         next_st.tmr_strap = strap_sync[0]; // see RL8
         next_st.boot_strap = strap_sync[1];
         next_st.boot_pend = strap_sync[1]; // see RL6
         next_st.exp_prev = TIMER0_EXPIRE_I;
      end
   end

   always_ff @(posedge CLK_I) begin
      st <= next_st;
   end

   // Level to the sequencer comes from the filter flop; pins driven out read back
   assign COND_LEVEL_O = cond_sync; // see RL3
   assign COND_PINS_O = st.dout;
   assign COND_PINS_OE_O = st.oe;
   assign IRQ_REQ_O = irq_req;
   assign TIMER0_EXPIRED_OUT_O = st.tmr_o;
   assign TIMER0_EXPIRED_OUT_OE_O = st.tmr_oe;
   assign TIMER0_STRAP_O = st.tmr_strap;
   assign INT_O = st.int_o;
   assign RDATA_O = st.rdata;

endmodule : fip_top

// File: verification/fip_top_sva.sv
// Port assertions for the flag, request and timer pin block
`timescale 1ns/1ps
module fip_top_sva
   import fip_pkg::*;
(
   // Clock, reset and register writes
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WE_I,
   // Pins
   input wire logic [3:0] COND_PINS_I,
   input wire logic [3:0] COND_PINS_OE_O,
   input wire logic [3:0] COND_LEVEL_O,
   input wire logic [3:0] EXT_IRQ_N_I,
   input wire logic [3:0] IRQ_REQ_O,
   input wire logic [3:0] IRQ_ACK_I,
   // Timer
   input wire logic TIMER0_EXPIRE_I,
   input wire logic TIMER0_EXPIRED_OUT_I,
   input wire logic TIMER0_EXPIRED_OUT_O,
   input wire logic TIMER0_EXPIRED_OUT_OE_O,
   input wire logic TIMER0_STRAP_O
);
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   property p_dir;
      $past(WE_I) && $past(ADDR_I) == ADDR_FLAG_DIR |-> COND_PINS_OE_O == $past(WDATA_I[3:0]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction write not applied");
   property p_rst_oe;
      disable iff (1'b0) RST_I |=> COND_PINS_OE_O == 4'h0;
   endproperty
   a_rst_oe: assert property (p_rst_oe) else $error("condition pin driven in reset");
   property p_lvl;
      $stable(COND_PINS_I) [*6] |-> COND_LEVEL_O == COND_PINS_I;
   endproperty
   a_lvl: assert property (p_lvl) else $error("condition level stale");
   // Synchroniser delay means a new request must trail the pin
   property p_irq_rise;
      (IRQ_REQ_O & ~$past(IRQ_REQ_O) & $past(EXT_IRQ_N_I, 3)) == 4'h0;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("request without asserted pin");
   property p_irq_hold;
      $past(WE_I) || $past(WE_I, 2) ||
         (~IRQ_REQ_O & $past(IRQ_REQ_O) & ~$past(IRQ_ACK_I) & ~$past(EXT_IRQ_N_I, 2)) == 4'h0;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("request dropped early");
   property p_boot;
      $fell(RST_I) |-> (IRQ_REQ_O == 4'h0) [*3];
   endproperty
   a_boot: assert property (p_boot) else $error("request right after reset");
   property p_tmr;
      $rose(TIMER0_EXPIRE_I) |=> TIMER0_EXPIRED_OUT_O ##1 !TIMER0_EXPIRED_OUT_O;
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer pulse wrong");
   property p_tmr_oe;
      disable iff (1'b0) 1'b1 |=> TIMER0_EXPIRED_OUT_OE_O == !$past(RST_I);
   endproperty
   a_tmr_oe: assert property (p_tmr_oe) else $error("timer pin enable wrong");
   property p_strap;
      $fell(RST_I) |=> TIMER0_STRAP_O == $past(TIMER0_EXPIRED_OUT_I, 2);
   endproperty
   a_strap: assert property (p_strap) else $error("timer strap not captured");
   c_req: cover property ($rose(IRQ_REQ_O[0]));
   c_tmr: cover property (TIMER0_EXPIRED_OUT_O);
   c_oe: cover property (|COND_PINS_OE_O);
endmodule : fip_top_sva
bind fip_top fip_top_sva fip_top_sva_i (.*);

// File: verification/fip_board.sv
// Board model: pull-ups, external flag drivers and the timer strap
`timescale 1ns/1ps
module fip_board (
   // Device side
   input wire logic [3:0] cond_o_i,
   input wire logic [3:0] cond_oe_i,
   input wire logic tmr_o_i,
   input wire logic tmr_oe_i,
   // Board controls
   input wire logic [3:0] drv_en_i,
   input wire logic [3:0] drv_val_i,
   input wire logic strap_i,
   // Pin levels
   output logic [3:0] cond_pin_o,
   output logic tmr_pin_o
);
   // Board backs off a driven pin; undriven pins go to the pull-up
   assign cond_pin_o = (cond_oe_i & cond_o_i) | (~cond_oe_i & (~drv_en_i | drv_val_i));
   assign tmr_pin_o = tmr_oe_i ? tmr_o_i : strap_i;
endmodule : fip_board

// File: verification/fip_top_tb.sv
// Self-checking bench for the flag, request and timer pin block
`timescale 1ns/1ps
module fip_top_tb;
   import fip_pkg::*;
   logic CLK_I = 0, RST_I = 1, WE_I = 0, RE_I = 0, VEC_INIT_I = 0, IRQ_BOOT_STRAP_I = 0, TIMER0_EXPIRE_I = 0;
   logic [3:0] ADDR_I = 4'h0, EXT_IRQ_N_I = 4'hf, IRQ_ACK_I = 4'h0, COND_PINS_I, COND_PINS_O, COND_PINS_OE_O;
   logic [3:0] COND_LEVEL_O, IRQ_REQ_O, en = 4'h0, val = 4'h0, d, o;
   logic [15:0] WDATA_I = 16'h0000, RDATA_O, v;
   logic TIMER0_EXPIRED_OUT_I, TIMER0_EXPIRED_OUT_O, TIMER0_EXPIRED_OUT_OE_O, TIMER0_STRAP_O, INT_O, strap = 1;
   int err_count = 0, checks = 0, seed = 30, cyc = 0;
   fip_top fip_top_i (.*);
   fip_board fip_board_i (.cond_o_i(COND_PINS_O), .cond_oe_i(COND_PINS_OE_O), .tmr_o_i(TIMER0_EXPIRED_OUT_O),
      .tmr_oe_i(TIMER0_EXPIRED_OUT_OE_O), .drv_en_i(en), .drv_val_i(val), .strap_i(strap),
      .cond_pin_o(COND_PINS_I), .tmr_pin_o(TIMER0_EXPIRED_OUT_I));
   initial begin
      forever #2.5 CLK_I = ~CLK_I;
   end
   always @(posedge CLK_I) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         stop_test;
      end
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   function automatic logic [3:0] pin_exp(input logic [3:0] dir, out, den, dval);
      return (dir & out) | (~dir & (~den | dval));
   endfunction : pin_exp
   task automatic wr(input logic [3:0] a, input logic [15:0] x);
      @(posedge CLK_I);
      WE_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= x;
      @(posedge CLK_I);
      WE_I <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge CLK_I);
      RE_I <= 1'b1;
      ADDR_I <= a;
      @(posedge CLK_I);
      RE_I <= 1'b0;
      #1 v = RDATA_O;
   endtask : rd
   // Five edges so the straps clear the input filter
   task automatic do_rst(input logic s, input logic b);
      @(posedge CLK_I);
      RST_I <= 1'b1;
      strap <= s;
      IRQ_BOOT_STRAP_I <= b;
      repeat (5) @(posedge CLK_I);
      RST_I <= 1'b0;
   endtask : do_rst
   initial begin
      do_rst(1'b1, 1'b0);
      #1 chk("cond_oe", 16'h0000, 16'(COND_PINS_OE_O));
      chk("strap_o", 16'h0001, 16'(TIMER0_STRAP_O));
      rd(ADDR_STRAP);
      chk("strap", 16'h0001, v);
      @(posedge CLK_I);
      #1 chk("rdata_gone", 16'h0000, RDATA_O);
      rd(ADDR_IRQ_EN);
      chk("irq_en", 16'h0000, v);
      rd(4'hf);
      chk("unmapped", 16'h0000, v);
      chk("tmr_oe", 16'h0001, 16'(TIMER0_EXPIRED_OUT_OE_O));
      $display("reset test done");
      repeat (8) begin
         d = 4'($random(seed));
         o = 4'($random(seed));
         @(posedge CLK_I);
         en <= 4'($random(seed));
         val <= 4'($random(seed));
         wr(ADDR_FLAG_DIR, 16'(d));
         wr(ADDR_FLAG_OUT, 16'(o));
         repeat (6) @(posedge CLK_I);
         #1 chk("oe", 16'(d), 16'(COND_PINS_OE_O));
         chk("out", 16'(o), 16'(COND_PINS_O));
         chk("level", 16'(pin_exp(d, o, en, val)), 16'(COND_LEVEL_O));
         rd(ADDR_FLAG_IN);
         chk("pin_reg", 16'(pin_exp(d, o, en, val)), v);
      end
      $display("direction test done");
      wr(ADDR_IRQ_MODE, 16'h0003);
      wr(ADDR_IRQ_EN, 16'h000f);
      wr(ADDR_EVT_STAT, 16'h01ff);
      wr(ADDR_EVT_MASK, 16'h000f);
      @(posedge CLK_I);
      EXT_IRQ_N_I <= 4'h0;
      repeat (8) @(posedge CLK_I);
      #1 chk("req_on", 16'h000f, 16'(IRQ_REQ_O));
      chk("int_on", 16'h0001, 16'(INT_O));
      @(posedge CLK_I);
      EXT_IRQ_N_I <= 4'hf;
      repeat (8) @(posedge CLK_I);
      #1 chk("req_held", 16'h0003, 16'(IRQ_REQ_O));
      rd(ADDR_IRQ_REQ);
      chk("req_reg", 16'h0003, v);
      @(posedge CLK_I);
      IRQ_ACK_I <= 4'h3;
      @(posedge CLK_I);
      IRQ_ACK_I <= 4'h0;
      @(posedge CLK_I);
      #1 chk("req_ack", 16'h0000, 16'(IRQ_REQ_O));
      rd(ADDR_EVT_STAT);
      chk("stat_irq", 16'h000f, v & 16'h000f);
      wr(ADDR_EVT_STAT, 16'h000f);
      rd(ADDR_EVT_STAT);
      chk("stat_w1c", 16'h0000, v & 16'h000f);
      chk("int_off", 16'h0000, 16'(INT_O));
      $display("request test done");
      repeat (2) begin
         @(posedge CLK_I);
         TIMER0_EXPIRE_I <= 1'b1;
         @(posedge CLK_I);
         TIMER0_EXPIRE_I <= 1'b0;
         #1 chk("tmr_pulse", 16'h0001, 16'(TIMER0_EXPIRED_OUT_O));
         @(posedge CLK_I);
         #1 chk("tmr_once", 16'h0000, 16'(TIMER0_EXPIRED_OUT_O));
      end
      rd(ADDR_EVT_STAT);
      chk("stat_tmr", 16'h0010, v & 16'h0010);
      chk("int_masked", 16'h0000, 16'(INT_O));
      $display("timer test done");
      do_rst(1'b0, 1'b1);
      #1 chk("strap_o_low", 16'h0000, 16'(TIMER0_STRAP_O));
      rd(ADDR_STRAP);
      chk("strap_boot", 16'h0006, v);
      @(posedge CLK_I);
      VEC_INIT_I <= 1'b1;
      rd(ADDR_IRQ_EN);
      chk("boot_en", 16'h000f, v);
      $display("boot test done");
      stop_test;
   end
endmodule : fip_top_tb
